// ### hdl/dttm_core.sv
`timescale 1ns/1ps
`include "dttm_defs.svh"
module dttm_core
  import dttm_pkg::*;
#(
  parameter int MS_CYCLES = `DTTM_MS_CYC
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    srst_i,
  // Trace records from the target
  input  wire logic                    rec_valid_i,
  output logic                         rec_ready_o,
  input  wire logic [1:0]              rec_kind_i,
  input  wire logic [2:0]              rec_event_i,
  input  wire logic [31:0]             rec_addr_i,
  input  wire logic [31:0]             rec_data_i,
  input  wire logic [1:0]              rec_size_i,
  input  wire logic                    rec_write_i,
  input  wire logic                    rec_dma_i,
  input  wire logic                    rec_in_queue_i,
  // Target run state
  input  wire logic                    run_i,
  // Event slot use
  input  wire logic [`DTTM_EV_NUM-1:0] trace_en_i,
  input  wire logic [`DTTM_EV_NUM-1:0] break_en_i,
  input  wire logic                    extract_en_i,
  output logic                         break_o,
  // Measurement setup
  input  wire logic                    meas_sel_i,
  input  wire logic                    sec_mode_i,
  input  wire logic [31:0]             sec_start_addr_i,
  input  wire logic [31:0]             sec_start_data_i,
  input  wire logic [1:0]              sec_start_size_i,
  input  wire logic                    sec_start_write_i,
  input  wire logic [31:0]             sec_end_addr_i,
  input  wire logic [31:0]             sec_end_data_i,
  input  wire logic [1:0]              sec_end_size_i,
  input  wire logic                    sec_end_write_i,
  // Measurement results
  output logic [`DTTM_EXEC_W-1:0]      exec_time_o,
  output logic [`DTTM_SEC_W-1:0]       sec_time_o,
  output logic                         sec_done_o,
  output logic                         sec_err_o,
  output logic                         misalign_o,
  output logic                         cfg_bad_o,
  // RAM monitor
  input  wire logic                    ram_mon_en_i,
  input  wire logic [15:0]             mon_ivl_ms_i,
  input  wire logic                    mon_half_i,
  output logic                         dbg_irq_o,
  output logic [2:0]                   dbg_event_o,
  input  wire logic                    mon_valid_i,
  input  wire logic [15:0]             mon_data_i,
  output logic [15:0]                  mon_data_o,
  output logic                         mon_done_o,
  // Trace memory
  output logic                         tm_valid_o,
  input  wire logic                    tm_ready_i,
  output logic [1:0]                   tm_kind_o,
  output logic [2:0]                   tm_event_o,
  output logic [31:0]                  tm_addr_o,
  output logic [31:0]                  tm_data_o,
  output logic [1:0]                   tm_size_o,
  output logic                         tm_write_o
);
  localparam logic [7:0]  TROUT_CYC = 8'(`DTTM_TROUT_CYC);
  localparam logic [7:0]  ASYNC_DIV = 8'(`DTTM_ASYNC_DIV);
  localparam logic [31:0] MS_LAST   = 32'(MS_CYCLES - 1);

  function automatic logic rec_match(input dttm_rec_t r, input logic [31:0] a,
                                     input logic [31:0] d, input logic [1:0] s,
                                     input logic w);
    rec_match = (r.addr == a) && (r.data == d) && (r.size == dttm_size_t'(s)) && (r.wr == w);
  endfunction

  function automatic logic misaligned(input logic [31:0] a, input dttm_size_t s);
    misaligned = ((s == DTTM_SZ_HALF) && a[0]) || ((s == DTTM_SZ_WORD) && (a[1:0] != 2'h0));
  endfunction

  function automatic logic excluded(input logic [31:0] a);
    excluded = (a >= `DTTM_EXCL_LO) && (a <= `DTTM_EXCL_HI);
  endfunction

  dttm_core_st_t st_ff;
  dttm_core_st_t nxt_st;
  dttm_rec_t     rec;
  dttm_rec_t     tm_rec;
  logic          fifo_ready;
  logic          acc;
  logic          keep;
  logic          push;
  logic          is_ev;
  logic          is_data;
  logic          cand;
  logic          hit_s;
  logic          hit_e;
  logic          tick;
  logic          ms_tick;

  assign rec.kind  = dttm_kind_t'(rec_kind_i);
  assign rec.ev    = rec_event_i;
  assign rec.addr  = rec_addr_i;
  assign rec.data  = rec_data_i;
  assign rec.size  = dttm_size_t'(rec_size_i);
  assign rec.wr    = rec_write_i;

  // A full buffer holds the target off, which is what slows the user program
  assign rec_ready_o = fifo_ready;
  assign acc         = rec_valid_i && fifo_ready;
  assign is_ev       = (rec.kind == DTTM_K_EVENT);
  assign is_data     = (rec.kind == DTTM_K_DATA);

  always_comb
  begin
    keep = 1'b0;
    unique case (rec.kind)
      DTTM_K_EVENT:  keep = trace_en_i[rec.ev];
      DTTM_K_BRANCH: keep = !rec_in_queue_i;
      DTTM_K_DATA:   keep = 1'b1;
      DTTM_K_CBR:    keep = 1'b1;
    endcase
    if (extract_en_i)
      keep = is_ev && st_ff.win_open && trace_en_i[rec.ev]
             && (rec.ev != `DTTM_EV_XSTART) && (rec.ev != `DTTM_EV_XEND);
  end

  assign push = acc && keep;

  // Only CPU data accesses of section mode take part in matching
  assign cand  = acc && is_data && !rec_dma_i && (meas_sel_i == DTTM_M_SEC);
  assign hit_s = cand && rec_match(rec, sec_start_addr_i, sec_start_data_i,
                                   sec_start_size_i, sec_start_write_i);
  assign hit_e = cand && rec_match(rec, sec_end_addr_i, sec_end_data_i,
                                   sec_end_size_i, sec_end_write_i);
  assign tick    = (st_ff.div_cnt == ASYNC_DIV - 8'h01);
  assign ms_tick = (st_ff.ms_cnt == MS_LAST);

  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.sec_done = 1'b0;
    nxt_st.sec_err  = 1'b0;
    nxt_st.brk      = 1'b0;
    nxt_st.mon_done = 1'b0;
    nxt_st.misalign = acc && is_data && misaligned(rec.addr, rec.size);
    nxt_st.cfg_bad  = excluded(sec_start_addr_i) || excluded(sec_end_addr_i);
    nxt_st.run_d    = run_i;

    if (meas_sel_i == DTTM_M_EXEC)
    begin
      if (run_i && !st_ff.run_d)
        nxt_st.exec_cnt = '0;
      else if (run_i)
        nxt_st.exec_cnt = st_ff.exec_cnt + 32'h0000_0001;
    end

    // The emulator's own slow clock, kept free-running in every mode
    nxt_st.div_cnt = tick ? 8'h00 : st_ff.div_cnt + 8'h01;
    if (tick)
      nxt_st.sec_cnt = st_ff.sec_cnt + 40'h00_0000_0001;

    if (acc && is_ev && break_en_i[rec.ev])
      nxt_st.brk = 1'b1;
    if (!extract_en_i)
      nxt_st.win_open = 1'b0;
    else if (acc && is_ev && (rec.ev == `DTTM_EV_XSTART))
      nxt_st.win_open = 1'b1;
    else if (acc && is_ev && (rec.ev == `DTTM_EV_XEND))
      nxt_st.win_open = 1'b0;

    // Trace output time guard between two matched accesses
    if (st_ff.gap_busy)
    begin
      if (st_ff.gap_cnt == 8'h00)
        nxt_st.gap_busy = 1'b0;
      else
        nxt_st.gap_cnt = st_ff.gap_cnt - 8'h01;
    end
    if (hit_s || hit_e)
    begin
      nxt_st.sec_err  = st_ff.gap_busy;
      nxt_st.gap_busy = 1'b1;
      nxt_st.gap_cnt  = TROUT_CYC - 8'h02;
    end

    if (meas_sel_i != DTTM_M_SEC)
      nxt_st.sec_st = DTTM_SEC_IDLE;
    else if (sec_mode_i == DTTM_SM_PERIOD)
    begin
      if (hit_s)
      begin
        if (st_ff.sec_st == DTTM_SEC_ARMED)
        begin
          nxt_st.sec_time = st_ff.sec_cnt - st_ff.sec_mark;
          nxt_st.sec_done = 1'b1;
        end
        nxt_st.sec_mark = st_ff.sec_cnt;
        nxt_st.sec_st   = DTTM_SEC_ARMED;
      end
    end
    else
    begin
      unique case (st_ff.sec_st)
        DTTM_SEC_IDLE:
          if (hit_s)
          begin
            nxt_st.sec_mark = st_ff.sec_cnt;
            nxt_st.sec_st   = DTTM_SEC_ARMED;
          end
        DTTM_SEC_ARMED:
          if (hit_e)
          begin
            nxt_st.sec_time = st_ff.sec_cnt - st_ff.sec_mark;
            nxt_st.sec_done = 1'b1;
            nxt_st.sec_st   = DTTM_SEC_IDLE;
          end
      endcase
    end

    nxt_st.ms_cnt = ms_tick ? 32'h0000_0000 : st_ff.ms_cnt + 32'h0000_0001;
    unique case (st_ff.mon_st)
      DTTM_MON_WAIT:
        if (!ram_mon_en_i || !run_i)
          nxt_st.ivl_cnt = 16'h0000;
        else if (ms_tick)
        begin
          if (st_ff.ivl_cnt + 16'h0001 >= mon_ivl_ms_i)
          begin
            nxt_st.ivl_cnt = 16'h0000;
            nxt_st.mon_st  = DTTM_MON_IRQ;
          end
          else
            nxt_st.ivl_cnt = st_ff.ivl_cnt + 16'h0001;
        end
      DTTM_MON_IRQ:
        if (mon_valid_i)
        begin
          // Byte samples keep only the low lane
          nxt_st.mon_data = mon_half_i ? mon_data_i : {8'h00, mon_data_i[7:0]};
          nxt_st.mon_done = 1'b1;
          nxt_st.mon_st   = DTTM_MON_WAIT;
        end
        else if (!ram_mon_en_i)
          nxt_st.mon_st = DTTM_MON_WAIT;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  dttm_fifo #(
    .W     ($bits(dttm_rec_t)),
    .DEPTH (`DTTM_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (rec),
    .out_valid_o (tm_valid_o),
    .out_ready_i (tm_ready_i),
    .out_data_o  (tm_rec)
  );

  assign tm_kind_o   = tm_rec.kind;
  assign tm_event_o  = tm_rec.ev;
  assign tm_addr_o   = tm_rec.addr;
  assign tm_data_o   = tm_rec.data;
  assign tm_size_o   = tm_rec.size;
  assign tm_write_o  = tm_rec.wr;
  assign break_o     = st_ff.brk;
  assign exec_time_o = st_ff.exec_cnt;
  assign sec_time_o  = st_ff.sec_time;
  assign sec_done_o  = st_ff.sec_done;
  assign sec_err_o   = st_ff.sec_err;
  assign misalign_o  = st_ff.misalign;
  assign cfg_bad_o   = st_ff.cfg_bad;
  assign dbg_irq_o   = (st_ff.mon_st == DTTM_MON_IRQ);
  assign dbg_event_o = `DTTM_EV_DCMP;
  assign mon_data_o  = st_ff.mon_data;
  assign mon_done_o  = st_ff.mon_done;

  default clocking dttm_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  chk_exec_clear_go:
    assert property ((meas_sel_i == DTTM_M_EXEC) && run_i && !st_ff.run_d
                     |=> exec_time_o == 32'h0000_0000)
    else $error("execution counter not cleared at go");
  chk_exec_count_run:
    assert property ((meas_sel_i == DTTM_M_EXEC) && run_i && st_ff.run_d
                     |=> exec_time_o == $past(exec_time_o) + 32'h0000_0001)
    else $error("execution counter missed a cycle");
  chk_exec_hold_stop:
    assert property (!run_i ##1 !run_i |-> $stable(exec_time_o))
    else $error("execution counter moved while stopped");
  chk_xwin_open_start:
    assert property (extract_en_i && acc && is_ev && rec.ev == `DTTM_EV_XSTART
                     ##1 extract_en_i |-> st_ff.win_open)
    else $error("extraction window did not open");
  chk_xwin_store_only:
    assert property (push && extract_en_i |-> is_ev && st_ff.win_open
                     && rec.ev != `DTTM_EV_XSTART && rec.ev != `DTTM_EV_XEND)
    else $error("record stored outside extraction filter");
  chk_queue_branch_drop:
    assert property (acc && rec.kind == DTTM_K_BRANCH && rec_in_queue_i |-> !push)
    else $error("in-queue branch stored");
  chk_dma_no_match:
    assert property (rec_dma_i || meas_sel_i == DTTM_M_EXEC |-> !hit_s && !hit_e)
    else $error("dma or execution mode produced a section match");
  chk_gap_err_flag:
    assert property ((hit_s || hit_e) ##[1:49] (hit_s || hit_e) |=> sec_err_o)
    else $error("back to back matches not flagged");
  chk_span_result:
    assert property (meas_sel_i == DTTM_M_SEC && sec_mode_i == DTTM_SM_SPAN
                     && st_ff.sec_st == DTTM_SEC_ARMED && hit_e
                     |=> sec_done_o && sec_time_o == $past(st_ff.sec_cnt - st_ff.sec_mark))
    else $error("span result wrong");
  chk_mon_irq_return:
    assert property (dbg_irq_o && mon_valid_i |=> !dbg_irq_o && mon_done_o)
    else $error("monitor interrupt not released after data");

endmodule

// ### shared/dttm_defs.svh
`ifndef DTTM_DEFS_SVH
`define DTTM_DEFS_SVH

// Event pool and the three slots with a fixed job
`define DTTM_EV_NUM       8
`define DTTM_EV_XSTART    3'h0
`define DTTM_EV_XEND      3'h4
`define DTTM_EV_DCMP      3'h5

// Counter widths
`define DTTM_EXEC_W       32
`define DTTM_SEC_W        40

// Address range in which no event may be placed
`define DTTM_EXCL_LO      32'h0100_0000
`define DTTM_EXCL_HI      32'hFEFF_FFFF

// Timing
`define DTTM_CLK_NS       100
`define DTTM_TROUT_NS     5000
`define DTTM_TROUT_CYC    (`DTTM_TROUT_NS / `DTTM_CLK_NS)
`define DTTM_MS_NS        1000000
`define DTTM_MS_CYC       (`DTTM_MS_NS / `DTTM_CLK_NS)
`define DTTM_ASYNC_DIV    2

// Buffering
`define DTTM_FIFO_DEPTH   4

`endif

// ### shared/dttm_pkg.sv
package dttm_pkg;

  typedef enum logic [1:0]
  {
    DTTM_K_EVENT  = 2'b00,
    DTTM_K_BRANCH = 2'b01,
    DTTM_K_DATA   = 2'b10,
    DTTM_K_CBR    = 2'b11
  } dttm_kind_t;

  typedef enum logic [1:0]
  {
    DTTM_SZ_BYTE = 2'b00,
    DTTM_SZ_HALF = 2'b01,
    DTTM_SZ_WORD = 2'b10,
    DTTM_SZ_RSVD = 2'b11
  } dttm_size_t;

  typedef enum logic
  {
    DTTM_M_EXEC = 1'b0,
    DTTM_M_SEC  = 1'b1
  } dttm_meas_t;

  typedef enum logic
  {
    DTTM_SM_SPAN   = 1'b0,
    DTTM_SM_PERIOD = 1'b1
  } dttm_secmode_t;

  typedef enum logic
  {
    DTTM_SEC_IDLE  = 1'b0,
    DTTM_SEC_ARMED = 1'b1
  } dttm_sec_st_t;

  typedef enum logic
  {
    DTTM_MON_WAIT = 1'b0,
    DTTM_MON_IRQ  = 1'b1
  } dttm_mon_st_t;

  typedef struct packed {
    dttm_kind_t  kind;
    logic [2:0]  ev;
    logic [31:0] addr;
    logic [31:0] data;
    dttm_size_t  size;
    logic        wr;
  } dttm_rec_t;

  typedef struct packed {
    logic          win_open;
    logic          run_d;
    logic [31:0]   exec_cnt;
    logic [7:0]    div_cnt;
    logic [39:0]   sec_cnt;
    dttm_sec_st_t  sec_st;
    logic [39:0]   sec_mark;
    logic [39:0]   sec_time;
    logic          sec_done;
    logic [7:0]    gap_cnt;
    logic          gap_busy;
    logic          sec_err;
    logic          misalign;
    logic          brk;
    logic          cfg_bad;
    dttm_mon_st_t  mon_st;
    logic [31:0]   ms_cnt;
    logic [15:0]   ivl_cnt;
    logic [15:0]   mon_data;
    logic          mon_done;
  } dttm_core_st_t;

endpackage

// ### hdl/dttm_fifo.sv
`timescale 1ns/1ps
module dttm_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } dttm_fifo_st_t;

  dttm_fifo_st_t st_ff;
  dttm_fifo_st_t nxt_st;
  logic          push;
  logic          pop;

  assign in_ready_o  = (st_ff.cnt != CW'(DEPTH));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o  = st_ff.mem[st_ff.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data_i;
      nxt_st.wp = (st_ff.wp == PW'(DEPTH - 1)) ? '0 : st_ff.wp + PW'(1);
    end
    if (pop)
      nxt_st.rp = (st_ff.rp == PW'(DEPTH - 1)) ? '0 : st_ff.rp + PW'(1);
    nxt_st.cnt = st_ff.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

endmodule

// ### test/dttm_tgt_model.sv
`timescale 1ns/1ps
module dttm_tgt_model
  import dttm_pkg::*;
(
  // Clock
  input  wire logic        sys_clk_i,
  // Trace records
  output logic             rec_valid_o,
  input  wire logic        rec_ready_i,
  output dttm_rec_t        rec_o,
  output logic             dma_o,
  output logic             inq_o,
  // Debug monitor answer
  input  wire logic        dbg_irq_i,
  input  wire logic [3:0]  dly_i,
  output logic             mon_valid_o,
  output logic [15:0]      mon_data_o
);
  logic [15:0] last_mon;

  task automatic send(input dttm_rec_t x, input logic d, input logic q);
    @(negedge sys_clk_i);
    rec_o = x;
    dma_o = d;
    inq_o = q;
    rec_valid_o = 1'h1;
    while (rec_ready_i !== 1'h1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    // Released lines show the inverse so a stale record cannot pass
    rec_valid_o = 1'h0;
    rec_o = ~x;
    dma_o = ~d;
    inq_o = ~q;
  endtask

  initial
  begin
    rec_valid_o = 1'h0;
    rec_o = '0;
    dma_o = 1'h0;
    inq_o = 1'h0;
    mon_valid_o = 1'h0;
    mon_data_o = 16'h0000;
    last_mon = 16'h0000;
    forever
    begin
      @(negedge sys_clk_i);
      if (dbg_irq_i === 1'h1)
      begin
        repeat (dly_i) @(negedge sys_clk_i);
        last_mon = 16'($urandom);
        mon_valid_o = dbg_irq_i;
        mon_data_o = last_mon;
        @(negedge sys_clk_i);
        mon_valid_o = 1'h0;
        mon_data_o = ~last_mon;
        @(negedge sys_clk_i);
      end
    end
  end
endmodule

// ### test/debug_trace_time_measure_tb_top.sv
`timescale 1ns/1ps
module debug_trace_time_measure_tb_top;
  import dttm_pkg::*;
  logic        sys_clk, srst, run, ext_en, msel, smode, mon_en, half, tm_rdy, win;
  logic        rv, rr, dma, inq, mv, brk, done, err, mis, bad, irq, mdone, tv, tm_w;
  logic [1:0]  tm_mode, tm_k, tm_s;
  logic [2:0]  dev, tm_e;
  logic [3:0]  dly;
  logic [7:0]  tr_en, brk_en;
  logic [15:0] ivl, mon_in, mon_out, exp_mon;
  logic [31:0] exec_t, tm_a, tm_d;
  logic [39:0] sec_t, last_sec;
  dttm_rec_t   rec, st_c, en_c, x;
  dttm_rec_t   exp_q[$];
  int          num_errors, samples_checked, brk_n, done_n, err_n, mis_n, mon_n;
  int          exp_brk, exp_mis, t, n;
  logic [31:0] bad_a [4] = '{32'h00ff_ffff, 32'h0100_0000, 32'hfeff_ffff, 32'hff00_0000};
  logic [2:0]  seq [14] = '{4, 1, 0, 1, 2, 3, 4, 5, 0, 5, 6, 7, 4, 6};

  dttm_core #(.MS_CYCLES(20)) dut_u (
    .sys_clk_i(sys_clk), .srst_i(srst), .rec_valid_i(rv), .rec_ready_o(rr),
    .rec_kind_i(rec.kind), .rec_event_i(rec.ev), .rec_addr_i(rec.addr),
    .rec_data_i(rec.data), .rec_size_i(rec.size), .rec_write_i(rec.wr),
    .rec_dma_i(dma), .rec_in_queue_i(inq), .run_i(run), .trace_en_i(tr_en),
    .break_en_i(brk_en), .extract_en_i(ext_en), .break_o(brk), .meas_sel_i(msel),
    .sec_mode_i(smode), .sec_start_addr_i(st_c.addr), .sec_start_data_i(st_c.data),
    .sec_start_size_i(st_c.size), .sec_start_write_i(st_c.wr),
    .sec_end_addr_i(en_c.addr), .sec_end_data_i(en_c.data),
    .sec_end_size_i(en_c.size), .sec_end_write_i(en_c.wr), .exec_time_o(exec_t),
    .sec_time_o(sec_t), .sec_done_o(done), .sec_err_o(err), .misalign_o(mis),
    .cfg_bad_o(bad), .ram_mon_en_i(mon_en), .mon_ivl_ms_i(ivl), .mon_half_i(half),
    .dbg_irq_o(irq), .dbg_event_o(dev), .mon_valid_i(mv), .mon_data_i(mon_in),
    .mon_data_o(mon_out), .mon_done_o(mdone), .tm_valid_o(tv), .tm_ready_i(tm_rdy),
    .tm_kind_o(tm_k), .tm_event_o(tm_e), .tm_addr_o(tm_a), .tm_data_o(tm_d),
    .tm_size_o(tm_s), .tm_write_o(tm_w)
  );

  dttm_tgt_model tgt_u (
    .sys_clk_i(sys_clk), .rec_valid_o(rv), .rec_ready_i(rr), .rec_o(rec),
    .dma_o(dma), .inq_o(inq), .dbg_irq_i(irq), .dly_i(dly), .mon_valid_o(mv),
    .mon_data_o(mon_in)
  );

  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic fail(input string m);
    num_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic cmp_val(input logic [39:0] g, input logic [39:0] e, input string m);
    samples_checked++;
    if (g !== e) fail(m);
  endtask

  // Slow tick phase makes the result one count either side of half the cycles
  task automatic cmp_near(input logic [39:0] g, input int c, input string m);
    samples_checked++;
    if ((g >= 40'(c / 2 - 1) && g <= 40'(c / 2 + 1)) !== 1'h1) fail(m);
  endtask

  task automatic cmp_rec();
    dttm_rec_t e;
    samples_checked++;
    if (exp_q.size() == 0) fail("unexpected trace record");
    else
    begin
      e = exp_q.pop_front();
      if ({tm_k, tm_e, tm_a, tm_d, tm_s, tm_w} !== e) fail("trace record");
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk);
  endtask

  task automatic do_reset();
    srst = 1'h1;
    cyc(5);
    srst = 1'h0;
  endtask

  task automatic send(input dttm_rec_t r, input logic d, input logic q);
    logic k;
    logic ev_hit;
    ev_hit = r.kind == DTTM_K_EVENT;
    k = !(r.kind == DTTM_K_BRANCH && q) && !(ev_hit && !tr_en[r.ev]);
    if (ext_en)
    begin
      k = ev_hit && win && r.ev != 3'h0 && r.ev != 3'h4 && tr_en[r.ev];
      if (ev_hit && r.ev inside {3'h0, 3'h4}) win = r.ev == 3'h0;
    end
    if (k) exp_q.push_back(r);
    if (ev_hit && brk_en[r.ev]) exp_brk++;
    if (r.kind == DTTM_K_DATA && (r.size == DTTM_SZ_HALF && r.addr[0]
        || r.size == DTTM_SZ_WORD && r.addr[1:0] != 2'h0)) exp_mis++;
    tgt_u.send(r, d, q);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(negedge sys_clk) tm_rdy <= (tm_mode == 2'h2) ? 1'($urandom) : tm_mode[0];

  always @(posedge sys_clk)
  begin
    if (srst === 1'h0)
    begin
      if (tv === 1'h1 && tm_rdy === 1'h1) cmp_rec();
      if (brk === 1'h1) brk_n++;
      if (err === 1'h1) err_n++;
      if (mis === 1'h1) mis_n++;
      if (done === 1'h1) done_n++;
      if (done === 1'h1) last_sec = sec_t;
      if (mdone === 1'h1) mon_n++;
      if (mdone === 1'h1) cmp_val(40'(mon_out), 40'(exp_mon), "monitor data");
      // Width is taken at the answer edge, as a width change may follow it
      if (mv === 1'h1) exp_mon = half ? tgt_u.last_mon : {8'h00, tgt_u.last_mon[7:0]};
    end
  end

  initial
  begin
    #(10000 * 100);
    fail("watchdog expired");
    complete_run();
  end

  initial
  begin
    void'($urandom(83));
    {srst, run, ext_en, msel, smode, mon_en, half, win, tm_mode, dly} = '0;
    {tr_en, brk_en, ivl} = '0;
    // Section conditions are writes, outside the excluded range except while the range check sets st_c.addr
    st_c = '{DTTM_K_DATA, 3'h0, 32'h0000_1000, 32'h0000_00a5, DTTM_SZ_WORD, 1'h1};
    en_c = '{DTTM_K_DATA, 3'h0, 32'h0000_2000, 32'h0000_005a, DTTM_SZ_WORD, 1'h1};
    cyc(1);
    do_reset();
    cmp_val(40'({rr, tv, irq, brk, done, dev}), 40'h85, "reset state");
    tr_en = 8'($urandom);
    brk_en = 8'($urandom);
    tm_mode = 2'h2;
    repeat (40)
    begin
      x = '{dttm_kind_t'($urandom % 4), 3'($urandom), $urandom, $urandom,
            dttm_size_t'($urandom % 3), 1'($urandom)};
      send(x, 1'($urandom), 1'($urandom));
    end
    // Empty the buffer first so that exactly four records fill it
    tm_mode = 2'h1;
    cyc(6);
    tm_mode = 2'h0;
    repeat (4) send(st_c, 1'h0, 1'h0);
    cyc(1);
    cmp_val(40'(rr), 40'h0, "fifo full refuses");
    tm_mode = 2'h1;
    ext_en = 1'h1;
    tr_en = 8'hff;
    foreach (seq[i]) send('{DTTM_K_EVENT, seq[i], 32'h0000_0400, 32'h0, DTTM_SZ_WORD, 1'h0},
      1'h0, 1'h0);
    send(st_c, 1'h0, 1'h0);
    ext_en = 1'h0;
    cyc(8);
    cmp_val(40'(exp_q.size()), 40'h0, "trace drained");
    cmp_val(40'(brk_n), 40'(exp_brk), "break count");
    cmp_val(40'(mis_n), 40'(exp_mis), "misalign count");
    run = 1'h1;
    t = $time;
    send(st_c, 1'h0, 1'h0);
    send(en_c, 1'h0, 1'h0);
    cyc(30);
    n = ($time - t) / 100;
    run = 1'h0;
    cyc(3);
    cmp_val(40'(exec_t), 40'(n - 1), "execution time");
    cmp_val(40'(done_n), 40'h0, "section idle in execution mode");
    msel = 1'h1;
    run = 1'h1;
    cyc(10);
    run = 1'h0;
    cmp_val(40'(exec_t), 40'(n - 1), "execution frozen");
    do_reset();
    send(st_c, 1'h0, 1'h0);
    t = $time;
    cyc(60);
    for (int i = 0; i < 5; i++)
    begin
      x = en_c;
      case (i)
        0: x.addr = en_c.addr + 32'h0000_0004;
        1: x.data = ~en_c.data;
        2: x.size = DTTM_SZ_HALF;
        3: x.wr = 1'h0;
        default: ;
      endcase
      send(x, i == 4, 1'h0);
    end
    cyc(60);
    send(en_c, 1'h0, 1'h0);
    n = ($time - t) / 100;
    cyc(3);
    cmp_val(40'(done_n), 40'h1, "one span result");
    cmp_near(last_sec, n, "span time");
    do_reset();
    smode = 1'h1;
    send(st_c, 1'h0, 1'h0);
    t = $time;
    repeat (2)
    begin
      cyc(55 + $urandom % 40);
      send(st_c, 1'h0, 1'h0);
      n = ($time - t) / 100;
      t = $time;
      cyc(3);
      cmp_near(last_sec, n, "period time");
    end
    cmp_val(40'(done_n), 40'h3, "period results");
    send(st_c, 1'h0, 1'h0);
    cyc(3);
    cmp_val(40'(err_n), 40'h1, "matches too close");
    for (int i = 0; i < 4; i++)
    begin
      st_c.addr = bad_a[i];
      cyc(2);
      cmp_val(40'(bad), 40'(i == 1 || i == 2), "excluded range");
    end
    st_c.addr = 32'h0000_1000;
    // No trace traffic while the monitor answers, so no DMA records either
    do_reset();
    msel = 1'h0;
    run = 1'h1;
    mon_en = 1'h1;
    ivl = 16'h0002;
    for (int p = 0; p < 2; p++)
    begin
      half = 1'(p);
      dly = 4'(p * 9);
      n = mon_n;
      cyc(300);
      cmp_val(40'(mon_n - n >= 5 && mon_n - n <= 8), 40'h1, "sample count");
    end
    cmp_val(40'(dev), 40'h5, "monitor event slot");
    mon_en = 1'h0;
    cyc(2);
    cmp_val(40'(irq), 40'h0, "interrupt dropped");
    cyc(12);
    complete_run();
  end
endmodule
